/* File: rtl/xbpm_defines.vh */
// Constants for the priority crossbar and port-match block.
`ifndef XBPM_DEFINES_VH
`define XBPM_DEFINES_VH
// Register addresses on the special function register port.
`define XBPM_ADDR_ROUTE0 8'hE1
`define XBPM_ADDR_ROUTE1 8'hE2
`define XBPM_ADDR_P1_EXPECT 8'hED
`define XBPM_ADDR_P1_MASK 8'hEE
`define XBPM_ADDR_P0_EXPECT 8'hFD
`define XBPM_ADDR_P0_MASK 8'hFE
// Reset values.
`define XBPM_RST_ROUTE 8'h00
`define XBPM_RST_EXPECT 8'hFF
`define XBPM_RST_MASK 8'h00
// Field positions in routing register 0.
`define XBPM_R0_UART 0
`define XBPM_R0_SPI 1
`define XBPM_R0_SMB0 2
`define XBPM_R0_SYSCK 3
`define XBPM_R0_CMP 4
`define XBPM_R0_CMPA 5
`define XBPM_R0_SMB1 6
`define XBPM_R0_STRONG 7
// Field positions in routing register 1.
`define XBPM_R1_PCA_LO 0
`define XBPM_R1_PCA_HI 1
`define XBPM_R1_ZERO 2
`define XBPM_R1_ECI 3
`define XBPM_R1_T0 4
`define XBPM_R1_T1 5
`define XBPM_R1_CROSSBAR_ENABLE_BIT 6
`define XBPM_R1_GLOBAL_PULLUP_DISABLE 7
// Crossbar pins: port 0 is 0..7, port 1 is 8..15, port 2 is 16..19.
`define XBPM_NPINS 20
`define XBPM_PORT_W 8
`define XBPM_P1_LO 8
`define XBPM_PIN_UART_TX 5'h04
`define XBPM_PIN_UART_RX 5'h05
`define XBPM_PIN_STRONG_A 18
`define XBPM_PIN_STRONG_B 19
// Peripheral signals in priority order.
`define XBPM_NSIG 19
`define XBPM_IDX_W 5
`define XBPM_SIG_TX 5'h00
`define XBPM_SIG_RX 5'h01
`define XBPM_SIG_SCK 2
`define XBPM_SIG_MISO 3
`define XBPM_SIG_MOSI 4
`define XBPM_SIG_NSS 5
`define XBPM_SIG_SDA0 6
`define XBPM_SIG_SCL0 7
`define XBPM_SIG_CMP 8
`define XBPM_SIG_CMPA 9
`define XBPM_SIG_SYSCK 10
`define XBPM_SIG_PCA_OUTPUT_ZERO 11
`define XBPM_SIG_CEX1 12
`define XBPM_SIG_CEX2 13
`define XBPM_SIG_ECI 14
`define XBPM_SIG_T0 15
`define XBPM_SIG_T1 16
`define XBPM_SIG_SDA1 17
`define XBPM_SIG_SCL1 18
`define XBPM_SIG_NONE 5'h1F
// SPI select mode code for 3-wire operation.
`define XBPM_SPI_3WIRE 2'h0
`endif

/* File: rtl/xbpm_crossbar.v */
// Priority crossbar pin assignment with port-match comparator.
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - An enabled SMBus claims data and clock; UART claims both its pins.
// - UART transmit always sits on port 0 bit 4, receive on bit 5.
// - Fixed priority order starting with UART and ending with SMBus1.
// - Each enabled function after UART takes the lowest pin not yet claimed.
// - Skipped pins are passed over as if already claimed.
// - Unclaimed pins stay general-purpose port pins.
// - SPI slave select claims a pin only in 4-wire mode.
// - Each SMBus pin order follows its pin-swap bit.
// - With the crossbar disabled all pins are plain port inputs.
// - Output drivers stay off while the crossbar is disabled.
// - Input mode 1 is digital, 0 analog; reset gives digital inputs.
// - Analog pins lose pull-up, output driver and digital receiver.
// - SMBus pins are always open-drain; others follow output mode.
// - Pull-up disable at 0 gives open-drain digital pins weak pull-ups.
// - Weak pull-up is off on any pin driving low.
// - Routing register 0 holds the seven enables and strong pull-up bit.
// - PCA field selects none, one, two or three compare outputs.
// - Routing register 1 holds timer and counter enables; bit 2 is zero.
// - Mismatch when masked port pins differ from masked expected values.
// - Mask bit 0 excludes a pin; masks reset to zero.
// - Expected bit selects low or high; expected values reset to ones.
// - Mismatch uses real pin levels whatever the routing is.
// - Mismatch drives both an interrupt request and a wake request.
//////////////////////////////////////////////////////////////////////////////
`include "xbpm_defines.vh"

module xbpm_crossbar (
    input wire sys_clk,
    input wire rst_n,
    input wire [7:0] sfr_addr,
    input wire sfr_wr,
    input wire sfr_rd,
    input wire [7:0] sfr_wdata,
    output reg [7:0] sfr_rdata,
    input wire [19:0] pin_input_mode,
    input wire [19:0] pin_output_mode,
    input wire [19:0] pin_skip_bits,
    input wire [19:0] port_latch,
    input wire [1:0] spi_select_mode_bits,
    input wire [1:0] smbus_pin_swap,
    input wire [18:0] periph_out,
    input wire [18:0] periph_oe,
    output reg [18:0] periph_in,
    input wire [19:0] pin_in,
    output reg [19:0] pin_out,
    output reg [19:0] pin_oe,
    output reg [19:0] pin_weak_pullup,
    output reg [19:0] pin_rx_en,
    output reg [1:0] pin_strong_pullup,
    output reg port_mismatch_irq,
    output reg port_mismatch_wake
);

    //////////////////////////////////////////////////////////////////////////
    // Register file.
    // Six byte-wide registers; the pin mode and skip settings live
    // outside this block and arrive as plain inputs.
    reg [7:0] route0;
    reg [7:0] route1;
    reg [7:0] p0_expect;
    reg [7:0] p0_mask;
    reg [7:0] p1_expect;
    reg [7:0] p1_mask;

    // Software writes land on the next edge; bit 2 of route1 is held zero.
    // Writes to addresses outside this block are ignored here, so the
    // other port registers can share the same special function bus.
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            route0 <= `XBPM_RST_ROUTE;
            route1 <= `XBPM_RST_ROUTE;
            p0_expect <= `XBPM_RST_EXPECT;
            p1_expect <= `XBPM_RST_EXPECT;
            p0_mask <= `XBPM_RST_MASK;
            p1_mask <= `XBPM_RST_MASK;
        end else if (sfr_wr) begin
            case (sfr_addr)
                `XBPM_ADDR_ROUTE0: begin
                    route0 <= sfr_wdata;
                end
                `XBPM_ADDR_ROUTE1: begin
                    route1 <= sfr_wdata;
                    route1[`XBPM_R1_ZERO] <= 1'b0;
                end
                `XBPM_ADDR_P0_EXPECT: begin
                    p0_expect <= sfr_wdata;
                end
                `XBPM_ADDR_P0_MASK: begin
                    p0_mask <= sfr_wdata;
                end
                `XBPM_ADDR_P1_EXPECT: begin
                    p1_expect <= sfr_wdata;
                end
                `XBPM_ADDR_P1_MASK: begin
                    p1_mask <= sfr_wdata;
                end
                default: begin
                    route0 <= route0;
                end
            endcase
        end
    end

    // Read data is registered one cycle after the read strobe.
    // The last value read is held until the next read strobe arrives.
    // Unmapped addresses return zero so a stray read is harmless.
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            sfr_rdata <= 8'h00;
        end else if (sfr_rd) begin
            case (sfr_addr)
                `XBPM_ADDR_ROUTE0: sfr_rdata <= route0;
                `XBPM_ADDR_ROUTE1: sfr_rdata <= route1;
                `XBPM_ADDR_P0_EXPECT: sfr_rdata <= p0_expect;
                `XBPM_ADDR_P0_MASK: sfr_rdata <= p0_mask;
                `XBPM_ADDR_P1_EXPECT: sfr_rdata <= p1_expect;
                `XBPM_ADDR_P1_MASK: sfr_rdata <= p1_mask;
                default: sfr_rdata <= 8'h00;
            endcase
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Decoded controls.
    wire xbar_en = route1[`XBPM_R1_CROSSBAR_ENABLE_BIT];
    wire pullup_off = route1[`XBPM_R1_GLOBAL_PULLUP_DISABLE];
    wire [1:0] pca_sel = route1[`XBPM_R1_PCA_HI:`XBPM_R1_PCA_LO];
    wire spi_4wire = (spi_select_mode_bits != `XBPM_SPI_3WIRE);
    reg [18:0] sig_en;

    // Per-signal enables; paired pins always enable together.
    // The crossbar enable is applied later at each pin cell, so the
    // assignment map stays stable while software flips the enable.
    always @* begin
        sig_en = 19'h00000;
        sig_en[`XBPM_SIG_TX] = route0[`XBPM_R0_UART];
        sig_en[`XBPM_SIG_RX] = route0[`XBPM_R0_UART];
        sig_en[`XBPM_SIG_SCK] = route0[`XBPM_R0_SPI];
        sig_en[`XBPM_SIG_MISO] = route0[`XBPM_R0_SPI];
        sig_en[`XBPM_SIG_MOSI] = route0[`XBPM_R0_SPI];
        sig_en[`XBPM_SIG_NSS] = route0[`XBPM_R0_SPI] & spi_4wire;
        sig_en[`XBPM_SIG_SDA0] = route0[`XBPM_R0_SMB0];
        sig_en[`XBPM_SIG_SCL0] = route0[`XBPM_R0_SMB0];
        sig_en[`XBPM_SIG_CMP] = route0[`XBPM_R0_CMP];
        sig_en[`XBPM_SIG_CMPA] = route0[`XBPM_R0_CMPA];
        sig_en[`XBPM_SIG_SYSCK] = route0[`XBPM_R0_SYSCK];
        sig_en[`XBPM_SIG_PCA_OUTPUT_ZERO] = (pca_sel != 2'h0);
        sig_en[`XBPM_SIG_CEX1] = pca_sel[`XBPM_R1_PCA_HI];
        sig_en[`XBPM_SIG_CEX2] = (pca_sel == 2'h3);
        sig_en[`XBPM_SIG_ECI] = route1[`XBPM_R1_ECI];
        sig_en[`XBPM_SIG_T0] = route1[`XBPM_R1_T0];
        sig_en[`XBPM_SIG_T1] = route1[`XBPM_R1_T1];
        sig_en[`XBPM_SIG_SDA1] = route0[`XBPM_R0_SMB1];
        sig_en[`XBPM_SIG_SCL1] = route0[`XBPM_R0_SMB1];
    end

    //////////////////////////////////////////////////////////////////////////
    // Priority decoder.
    reg [19:0] claimed;
    reg [19:0] pin_hit;
    reg [99:0] pin_sig;
    reg [18:0] sig_hit;
    reg [94:0] sig_pin;
    reg found;
    integer k;
    integer s;
    integer p;

    // Walk signals in priority order, giving each the lowest free pin.
    // The walk is fully combinational: seventeen signals by twenty pins
    // unroll into a long chain, which is the main timing path of the block.
    // Skip bits seed the claimed set, so skipped pins look already taken.
    always @* begin
        claimed = pin_skip_bits;
        pin_hit = 20'h00000;
        pin_sig = {`XBPM_NPINS{`XBPM_SIG_NONE}};
        sig_hit = 19'h00000;
        sig_pin = 95'h0;
        found = 1'b0;
        s = 0;
        p = 0;
        // UART is pinned regardless of skip bits.
        if (sig_en[`XBPM_SIG_TX]) begin
            claimed[`XBPM_PIN_UART_TX] = 1'b1;
            claimed[`XBPM_PIN_UART_RX] = 1'b1;
            pin_hit[`XBPM_PIN_UART_TX] = 1'b1;
            pin_hit[`XBPM_PIN_UART_RX] = 1'b1;
            pin_sig[`XBPM_PIN_UART_TX*`XBPM_IDX_W +: `XBPM_IDX_W] =
                `XBPM_SIG_TX;
            pin_sig[`XBPM_PIN_UART_RX*`XBPM_IDX_W +: `XBPM_IDX_W] =
                `XBPM_SIG_RX;
            sig_hit[`XBPM_SIG_TX] = 1'b1;
            sig_hit[`XBPM_SIG_RX] = 1'b1;
            sig_pin[`XBPM_SIG_TX*`XBPM_IDX_W +: `XBPM_IDX_W] =
                `XBPM_PIN_UART_TX;
            sig_pin[`XBPM_SIG_RX*`XBPM_IDX_W +: `XBPM_IDX_W] =
                `XBPM_PIN_UART_RX;
        end
        for (k = `XBPM_SIG_SCK; k < `XBPM_NSIG; k = k + 1) begin
            s = k;
            // A set swap bit places clock before data.
            if (smbus_pin_swap[0] && k == `XBPM_SIG_SDA0) s = `XBPM_SIG_SCL0;
            if (smbus_pin_swap[0] && k == `XBPM_SIG_SCL0) s = `XBPM_SIG_SDA0;
            if (smbus_pin_swap[1] && k == `XBPM_SIG_SDA1) s = `XBPM_SIG_SCL1;
            if (smbus_pin_swap[1] && k == `XBPM_SIG_SCL1) s = `XBPM_SIG_SDA1;
            found = 1'b0;
            if (sig_en[s]) begin
                for (p = 0; p < `XBPM_NPINS; p = p + 1) begin
                    if (!found && !claimed[p]) begin
                        found = 1'b1;
                        claimed[p] = 1'b1;
                        pin_hit[p] = 1'b1;
                        pin_sig[p*`XBPM_IDX_W +: `XBPM_IDX_W] = s[4:0];
                        sig_hit[s] = 1'b1;
                        sig_pin[s*`XBPM_IDX_W +: `XBPM_IDX_W] = p[4:0];
                    end
                end
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Pin input synchroniser; the first stage feeds only the second.
    // Both stages reset high, matching an idle pad with its pull-up on,
    // so no false mismatch follows reset.
    reg [19:0] pin_sync1;
    reg [19:0] pin_sync2;

    always @(posedge sys_clk) begin
        if (!rst_n) begin
            pin_sync1 <= 20'hFFFFF;
            pin_sync2 <= 20'hFFFFF;
        end else begin
            pin_sync1 <= pin_in;
            pin_sync2 <= pin_sync1;
        end
    end

    // Analog pins have no receiver and read as low.
    // Masking here keeps analog pins out of both the peripheral inputs
    // and the port-match compare.
    wire [19:0] pin_level = pin_sync2 & pin_input_mode;

    //////////////////////////////////////////////////////////////////////////
    // Pin cells.
    // A routed pin takes value and drive request from its peripheral; a
    // free pin with the crossbar on behaves as a general-purpose output.
    // Open-drain pins never drive high, and SMBus pins are always
    // open-drain whatever the output mode says.
    genvar g;
    generate
        for (g = 0; g < `XBPM_NPINS; g = g + 1) begin : g_pin
            wire [4:0] fn = pin_sig[g*`XBPM_IDX_W +: `XBPM_IDX_W];
            wire routed = pin_hit[g] & xbar_en;
            wire is_smbus = routed & ((fn == `XBPM_SIG_SDA0) |
                (fn == `XBPM_SIG_SCL0) | (fn == `XBPM_SIG_SDA1) |
                (fn == `XBPM_SIG_SCL1));
            wire digital = pin_input_mode[g];
            wire val = routed ? periph_out[fn] : port_latch[g];
            wire want = routed ? periph_oe[fn] : 1'b1;
            wire push = pin_output_mode[g] & ~is_smbus;
            wire drv_lo = xbar_en & digital & want & ~val;
            wire drv_hi = xbar_en & digital & want & val & push;

            // Pad controls are registered so a setting acts one edge later.
            // Registering also hides glitches of the long priority chain.
            always @(posedge sys_clk) begin
                if (!rst_n) begin
                    pin_out[g] <= 1'b1;
                    pin_oe[g] <= 1'b0;
                    pin_weak_pullup[g] <= 1'b1;
                    pin_rx_en[g] <= 1'b1;
                end else begin
                    pin_out[g] <= val;
                    pin_oe[g] <= drv_lo | drv_hi;
                    pin_weak_pullup[g] <= digital & ~pullup_off &
                        ~drv_lo & ~drv_hi;
                    pin_rx_en[g] <= digital;
                end
            end
        end
    endgenerate

    //////////////////////////////////////////////////////////////////////////
    // Peripheral inputs return the level of the pin they own, else idle high.
    // Idle high keeps serial receivers quiet while no pin is assigned.
    generate
        for (g = 0; g < `XBPM_NSIG; g = g + 1) begin : g_sig
            wire [4:0] at = sig_pin[g*`XBPM_IDX_W +: `XBPM_IDX_W];

            always @(posedge sys_clk) begin
                if (!rst_n) begin
                    periph_in[g] <= 1'b1;
                end else begin
                    periph_in[g] <= (sig_hit[g] & xbar_en) ?
                        pin_level[at] : 1'b1;
                end
            end
        end
    endgenerate

    //////////////////////////////////////////////////////////////////////////
    // Strong pull-ups on the two port 2 pins.
    // They follow the routing bit even with the crossbar disabled.
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            pin_strong_pullup <= 2'h0;
        end else begin
            pin_strong_pullup <= {2{route0[`XBPM_R0_STRONG]}};
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Port match comparator on the true pin levels, not the routing.
    wire [7:0] p0_now = pin_level[`XBPM_PORT_W-1:0];
    wire [7:0] p1_now = pin_level[`XBPM_P1_LO +: `XBPM_PORT_W];
    wire mismatch = ((p0_now & p0_mask) != (p0_expect & p0_mask)) |
        ((p1_now & p1_mask) != (p1_expect & p1_mask));

    // The level is re-evaluated every cycle and feeds both requests.
    // The request is a level, not a pulse: it stays high while the
    // masked pins differ and drops when they match again.
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            port_mismatch_irq <= 1'b0;
            port_mismatch_wake <= 1'b0;
        end else begin
            port_mismatch_irq <= mismatch;
            port_mismatch_wake <= mismatch;
        end
    end

endmodule // xbpm_crossbar

/* File: tb/xbpm_pad_model.sv */
// Pad model that resolves each crossbar pin level seen by the block.
`timescale 1ns/1ps
module xbpm_pad_model (
    input wire sys_clk,
    input wire [19:0] pin_out,
    input wire [19:0] pin_oe,
    input wire [19:0] pin_weak_pullup,
    input wire [19:0] ext_en,
    input wire [19:0] ext_val,
    output wire [19:0] pin_in
);
    reg [19:0] wander = 20'hA5A5A;
    ////////////////////////////////////////////////////////////////////////
    // A pad nobody drives or pulls shows a level that changes every cycle.
    always @(posedge sys_clk) begin
        wander <= ~wander;
    end
    // The block's drive wins, then an outside driver, then the pull-up.
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val) |
        (~pin_oe & ~ext_en & (pin_weak_pullup | wander));
endmodule // xbpm_pad_model

/* File: tb/xbpm_crossbar_assertions.sv */
// Concurrent checks on the ports of the crossbar and port-match block.
`timescale 1ns/1ps
`include "xbpm_defines.vh"
module xbpm_crossbar_chk (
    input wire sys_clk,
    input wire rst_n,
    input wire [7:0] sfr_addr,
    input wire sfr_wr,
    input wire sfr_rd,
    input wire [7:0] sfr_wdata,
    input wire [7:0] sfr_rdata,
    input wire [19:0] pin_input_mode,
    input wire [18:0] periph_out,
    input wire [18:0] periph_oe,
    input wire [18:0] periph_in,
    input wire [19:0] pin_out,
    input wire [19:0] pin_oe,
    input wire [19:0] pin_weak_pullup,
    input wire [19:0] pin_rx_en,
    input wire [1:0] pin_strong_pullup,
    input wire port_mismatch_irq,
    input wire port_mismatch_wake
);
    reg xb;
    reg wpd;
    reg ue;
    reg sp;
    ////////////////////////////////////////////////////////////////////////
    // Shadow copies of the routing bits, taken from register writes.
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            {wpd, xb, ue, sp} <= 4'h0;
        end else if (sfr_wr && sfr_addr == `XBPM_ADDR_ROUTE1) begin
            {wpd, xb} <= sfr_wdata[7:6];
        end else if (sfr_wr && sfr_addr == `XBPM_ADDR_ROUTE0) begin
            {sp, ue} <= {sfr_wdata[7], sfr_wdata[0]};
        end
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    sequence s_xb_off;
        !xb ##1 !xb;
    endsequence
    sequence s_off_write;
        (sfr_wr && sfr_addr == `XBPM_ADDR_ROUTE1 && !sfr_wdata[6]) ##1 1'b1;
    endsequence
    sequence s_rd_route1;
        sfr_rd && sfr_addr == `XBPM_ADDR_ROUTE1;
    endsequence
    ////////////////////////////////////////////////////////////////////////
    chk_off_quiet: assert property (s_xb_off |->
        pin_oe == 20'h00000 && periph_in == 19'h7FFFF)
        else $error("drive or input seen with crossbar off");
    chk_off_write: assert property (
        s_off_write |=> pin_oe == 20'h00000)
        else $error("drivers still on after crossbar disable write");
    chk_analog_quiet: assert property ($past(rst_n) |->
        ((pin_oe | pin_weak_pullup | pin_rx_en) & ~$past(pin_input_mode))
        == 20'h00000) else $error("analog pin not fully quiet");
    chk_rx_mode: assert property ($past(rst_n) |->
        pin_rx_en == $past(pin_input_mode))
        else $error("receiver enable wrong");
    chk_pullup_eq: assert property ($past(rst_n) |->
        pin_weak_pullup == ($past(pin_input_mode) & ~pin_oe &
        {20{!$past(wpd)}})) else $error("weak pull-up pattern wrong");
    chk_low_nopull: assert property (
        (pin_oe & ~pin_out & pin_weak_pullup) == 20'h00000)
        else $error("pull-up on while driving low");
    chk_uart_tx: assert property ((xb && ue && pin_input_mode[4] &&
        periph_oe[0] && !periph_out[0]) |=> pin_oe[4] && !pin_out[4])
        else $error("transmit not on port 0 bit 4");
    chk_strong_pu: assert property ($past(rst_n) |->
        pin_strong_pullup == {2{$past(sp)}})
        else $error("strong pull-up wrong");
    chk_rd_zero: assert property (s_rd_route1 |=> !sfr_rdata[2])
        else $error("routing register 1 bit 2 not zero");
    chk_irq_wake: assert property (
        port_mismatch_irq == port_mismatch_wake)
        else $error("interrupt and wake requests differ");
endmodule // xbpm_crossbar_chk
bind xbpm_crossbar xbpm_crossbar_chk u_xbpm_crossbar_chk (.sys_clk, .rst_n,
    .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata, .pin_input_mode,
    .periph_out, .periph_oe, .periph_in, .pin_out, .pin_oe, .pin_weak_pullup,
    .pin_rx_en, .pin_strong_pullup, .port_mismatch_irq, .port_mismatch_wake);

/* File: tb/tb_top.sv */
// Self-checking bench for the crossbar and port-match block.
`timescale 1ns/1ps
`include "xbpm_defines.vh"
module tb_top;
    typedef struct {string name; int sel; logic [19:0] exp; int due;}
        xbpm_note_t;
    reg sys_clk = 1'b0, rst_n = 1'b0, sfr_wr = 1'b0, sfr_rd = 1'b0;
    reg [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00;
    reg [19:0] pin_input_mode = 20'hFFFFF, pin_output_mode = 20'h00000;
    reg [19:0] pin_skip_bits = 20'h00000, port_latch = 20'hFFFFF;
    reg [19:0] ext_en = 20'h00000, ext_val = 20'h00000;
    reg [1:0] spi_select_mode_bits = 2'h0, smbus_pin_swap = 2'h0;
    reg [18:0] periph_out = 19'h00000, periph_oe = 19'h00000;
    wire [7:0] sfr_rdata;
    wire [18:0] periph_in;
    wire [19:0] pin_in, pin_out, pin_oe, pin_weak_pullup, pin_rx_en;
    wire [1:0] pin_strong_pullup;
    wire port_mismatch_irq, port_mismatch_wake;
    int n_mismatch = 0, n_compared = 0, cyc = 0, i, rnd;
    logic [7:0] d, m0, m1, e0, e1;
    logic [19:0] e;
    logic mm;
    xbpm_note_t q[$];
    xbpm_note_t nt;
    xbpm_crossbar u_xbpm_crossbar (.sys_clk, .rst_n, .sfr_addr, .sfr_wr,
        .sfr_rd, .sfr_wdata, .sfr_rdata, .pin_input_mode, .pin_output_mode,
        .pin_skip_bits, .port_latch, .spi_select_mode_bits, .smbus_pin_swap,
        .periph_out, .periph_oe, .periph_in, .pin_in, .pin_out, .pin_oe,
        .pin_weak_pullup, .pin_rx_en, .pin_strong_pullup, .port_mismatch_irq,
        .port_mismatch_wake);
    xbpm_pad_model u_xbpm_pad_model (.sys_clk, .pin_out, .pin_oe,
        .pin_weak_pullup, .ext_en, .ext_val, .pin_in);
    ////////////////////////////////////////////////////////////////////////
    // Clock of 20 ns period.
    always #10 sys_clk = ~sys_clk;
    // Picks the output that a note refers to.
    function automatic logic [19:0] pick(input int sel);
        case (sel)
            0: pick = {12'h000, sfr_rdata};
            1: pick = pin_oe;
            3: pick = pin_weak_pullup;
            4: pick = {1'b0, periph_in};
            5: pick = {18'h00000, port_mismatch_irq, port_mismatch_wake};
            6: pick = {19'h00000, periph_in[1]};
            default: pick = pin_rx_en;
        endcase
    endfunction
    task check(input string name, input logic [19:0] seen,
        input logic [19:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task note(input string name, input int sel, input logic [19:0] exp,
        input int dly);
        q.push_back('{name, sel, exp, cyc + dly});
    endtask
    task settle;
        @(posedge sys_clk);
        #1;
    endtask
    task wr(input logic [7:0] a, input logic [7:0] v);
        sfr_addr = a;
        sfr_wdata = v;
        sfr_wr = 1'b1;
        @(posedge sys_clk);
        #1 sfr_wr = 1'b0;
        settle;
    endtask
    task rd(input logic [7:0] a, input logic [7:0] v);
        sfr_addr = a;
        sfr_rd = 1'b1;
        @(posedge sys_clk);
        #1 sfr_rd = 1'b0;
        note("sfr_rdata", 0, {12'h000, v}, 0);
        settle;
    endtask
    task pins(input logic [19:0] oe, input logic [19:0] pu);
        note("pin_oe", 1, oe, 0);
        note("pin_weak_pullup", 3, pu, 0);
    endtask
    task complete_run;
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Watcher: once each edge has settled, compares every note now due.
    always @(posedge sys_clk) begin
        cyc = cyc + 1;
        #2;
        while (q.size() > 0 && q[0].due <= cyc) begin
            nt = q.pop_front();
            check(nt.name, pick(nt.sel), nt.exp);
        end
    end
    // Main sequence of scenarios.
    initial begin
        rnd = $urandom(20);
        repeat (2) @(posedge sys_clk);
        #1 rst_n = 1'b1;
        rd(`XBPM_ADDR_ROUTE0, 8'h00);
        rd(`XBPM_ADDR_ROUTE1, 8'h00);
        rd(`XBPM_ADDR_P0_EXPECT, 8'hFF);
        rd(`XBPM_ADDR_P1_EXPECT, 8'hFF);
        rd(`XBPM_ADDR_P0_MASK, 8'h00);
        rd(`XBPM_ADDR_P1_MASK, 8'h00);
        rd(8'h00, 8'h00);
        pins(20'h00000, 20'hFFFFF);
        d = 8'($urandom);
        wr(`XBPM_ADDR_P0_MASK, d);
        rd(`XBPM_ADDR_P0_MASK, d);
        wr(`XBPM_ADDR_ROUTE1, 8'hFF);
        rd(`XBPM_ADDR_ROUTE1, 8'hFB);
        wr(`XBPM_ADDR_ROUTE0, 8'hFF);
        rd(`XBPM_ADDR_ROUTE0, 8'hFF);
        // Routing register 0 enables and all PCA outputs set but crossbar off: pins stay plain inputs.
        periph_oe = 19'h7FFFF;
        pin_output_mode = 20'hFFFFF;
        port_latch = 20'h00000;
        wr(`XBPM_ADDR_ROUTE1, 8'h03);
        pins(20'h00000, 20'hFFFFF);
        note("periph_in", 4, 20'h7FFFF, 0);
        // Modes, outputs and skips first, then routing, then crossbar enable.
        pin_input_mode = 20'h7FFFF;
        pin_output_mode = 20'h00000;
        pin_skip_bits = 20'h8000C;
        port_latch = 20'hFFFFF;
        periph_oe = 19'h7FFFD;
        periph_out = 19'h00000;
        ext_en = 20'h00020;
        ext_val = 20'($urandom);
        wr(`XBPM_ADDR_ROUTE0, 8'h05);
        for (i = 0; i < 4; i++) begin
            wr(`XBPM_ADDR_ROUTE1, 8'h40 | 8'(i));
            e = 20'h00013 | (((20'h1 << i) - 20'h1) << 6);
            pins(e, 20'h7FFFF & ~e);
            note("rx_pin", 6, {19'h00000, ext_val[5]}, 2);
            repeat (2) settle;
        end
        wr(`XBPM_ADDR_ROUTE1, 8'hC1);
        pins(20'h00053, 20'h00000);
        note("pin_rx_en", 7, 20'h7FFFF, 0);
        wr(`XBPM_ADDR_ROUTE1, 8'h41);
        // SMBus data high on a push-pull pin still only drives open-drain.
        pin_output_mode = 20'h00003;
        periph_out = 19'h00040;
        for (i = 0; i < 2; i++) begin
            smbus_pin_swap = 2'(i);
            settle;
            note("pin_oe", 1, i ? 20'h00051 : 20'h00052, 0);
        end
        // Slave select claims a pin only outside 3-wire mode.
        pin_output_mode = 20'h00000;
        periph_out = 19'h00000;
        periph_oe = 19'h00800;
        pin_skip_bits = 20'h80000;
        wr(`XBPM_ADDR_ROUTE0, 8'h02);
        for (i = 0; i < 4; i++) begin
            spi_select_mode_bits = 2'(i);
            settle;
            note("pin_oe", 1, i ? 20'h00010 : 20'h00008, 0);
        end
        // Priority chain through clock out, counter input, timers, SMBus1.
        spi_select_mode_bits = 2'h0;
        periph_oe = 19'h40C00;
        wr(`XBPM_ADDR_ROUTE0, 8'h5A);
        wr(`XBPM_ADDR_ROUTE1, 8'h79);
        note("pin_oe", 1, 20'h00430, 0);
        // Port match on pins the block leaves undriven.
        periph_oe = 19'h00000;
        wr(`XBPM_ADDR_ROUTE0, 8'h00);
        wr(`XBPM_ADDR_ROUTE1, 8'h40);
        ext_en = 20'h0FFFF;
        for (i = 0; i < 8; i++) begin
            {m0, m1, e0, e1} = $urandom;
            wr(`XBPM_ADDR_P0_MASK, m0);
            wr(`XBPM_ADDR_P1_MASK, m1);
            wr(`XBPM_ADDR_P0_EXPECT, e0);
            wr(`XBPM_ADDR_P1_EXPECT, e1);
            ext_val = 20'($urandom);
            mm = ((ext_val[7:0] & m0) != (e0 & m0)) ||
                ((ext_val[15:8] & m1) != (e1 & m1));
            e = {18'h00000, mm, mm};
            note("irq", 5, e, 3);
            repeat (4) settle;
        end
        for (i = 0; i < 20 && q.size() > 0; i++) begin
            settle;
        end
        if (q.size() > 0) begin
            n_mismatch++;
        end
        complete_run;
    end
endmodule // tb_top
